// ==== logic/sti_pkg.sv ====
// shared constants for the frame timer and interrupt status block
package sti_pkg;
  // register offsets on the eight-bit register port
  localparam logic [7:0] ADDR_FLAGS    = 8'h0D;
  localparam logic [7:0] ADDR_REV_LOW  = 8'h0E;
  localparam logic [7:0] ADDR_HIGH_CNT = 8'h0F;

  // status bit positions
  localparam int BIT_DPLUS  = 7;
  localparam int BIT_DETECT = 6;
  localparam int BIT_INSERT = 5;
  localparam int BIT_SOF    = 4;
  localparam int BIT_DONE_B = 1;
  localparam int BIT_DONE_A = 0;

  // sticky flags software can clear; bits 7, 3 and 2 are not storage
  localparam logic [7:0] FLAG_MASK   = 8'h73;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // interval timer geometry
  localparam int INTERVAL_W  = 14;
  localparam int FRAME_W     = 11;
  localparam int HIGH_SHIFT  = 6;
  localparam logic [7:0]  LOW_RESET   = 8'h00;
  localparam logic [5:0]  HIGH_RESET  = 6'h00;
  localparam logic [10:0] FRAME_RESET = 11'h000;

  // bit-time tick derived from the system clock by a fractional accumulator
  localparam int CLK_MHZ  = 200;
  localparam int TICK_MHZ = 12;
  localparam int ACC_W    = 8;
endpackage

// ==== logic/sti_interval.sv ====
// fourteen-bit frame interval down-counter on a 12 MHz bit-time tick
module sti_interval
  import sti_pkg::*;
#(
  parameter int CLK_FREQ_MHZ  = CLK_MHZ,
  parameter int TICK_FREQ_MHZ = TICK_MHZ
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // configuration
  input  wire logic                  i_enable,
  input  wire logic [7:0]            i_low,
  input  wire logic [5:0]            i_high,
  // state
  output logic [INTERVAL_W-1:0]      o_count,
  output logic                       o_tick
);
  localparam logic [ACC_W-1:0] STEP = ACC_W'(TICK_FREQ_MHZ);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_FREQ_MHZ);

  logic [ACC_W-1:0]      acc;
  logic [ACC_W:0]        acc_sum;
  logic                  bit_tick;
  logic [ACC_W-1:0]      next_acc;
  logic [INTERVAL_W-1:0] next_count;
  logic [INTERVAL_W-1:0] reload;

  // 200 is not a multiple of 12, so ticks jitter by one cycle but average 12 MHz
  assign acc_sum  = {1'b0, acc} + {1'b0, STEP};
  assign bit_tick = acc_sum >= {1'b0, WRAP};
  assign next_acc = bit_tick ? ACC_W'(acc_sum - {1'b0, WRAP}) : acc_sum[ACC_W-1:0];

  assign reload     = {i_high, i_low};
  assign o_tick     = i_enable && bit_tick && (o_count == '0);
  assign next_count = o_tick ? reload : o_count - INTERVAL_W'(1);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // counter holds while generation is off
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= '0;
    end else if (i_enable && bit_tick) begin
      o_count <= next_count;
    end
  end

  a_reload_value: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tick |=> o_count == $past(reload))
    else $error("interval count not reloaded after reaching zero");

  a_count_down: assert property (@(posedge i_clk) disable iff (i_rst)
    i_enable && bit_tick && o_count != '0 |=> o_count == $past(o_count) - INTERVAL_W'(1))
    else $error("interval count did not step down by one");

  a_tick_rate: assert property (@(posedge i_clk) disable iff (i_rst)
    bit_tick |=> !bit_tick [*8] ##1 !bit_tick [*7])
    else $error("bit-time tick faster than 12 MHz");
endmodule

// ==== logic/sti_timer.sv ====
// interrupt status flags, revision read-back and start-of-frame timer
// Overview of operation
// - status bit 7 always shows the D+ line; 0 low speed, 1 full speed
// - with resume mode selected, status bit 6 is the resume interrupt flag
// - otherwise status bit 6 reads 1 with nothing attached, 0 when attached
// - in host mode, attach or detach transitions set status bit 5
// - status bit 4 is set whenever a frame interval elapses
// - status bits 1 and 0 flag packet done on transfer sets B and A
// - reading offset 0Eh gives revision in bits 7-4, zeros in bits 3-0
// - writing 0Eh loads interval low byte; timer runs from a 12 MHz tick
// - reading 0Fh gives interval count bits 13 to 6
// - interval count steps once per 12 MHz period, one full-speed bit time
// - any write to 0Fh clears the frame number counter
// - frame number is eleven bits, incremented on every frame tick without a same-cycle 0Fh write
// - each frame tick sends the frame number in a start-of-frame packet
// - writing ones to status clears just those flags
// - interrupt request is a level held while any enabled flag stays set
// - writing 0Fh bits 5-0 loads interval high bits; timer counts down
// - frame generation runs only while control bit 0 is one
module sti_timer
  import sti_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h3  // arbitrary value
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // register port
  input  wire logic [7:0]        i_addr,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [7:0]        i_wdata,
  output logic [7:0]             o_rdata,
  // controls held elsewhere
  input  wire logic              i_host_mode,
  input  wire logic              i_resume_mode,
  input  wire logic              i_sof_enable,
  input  wire logic [7:0]        i_irq_enable,
  // events from the packet engines and line monitor
  input  wire logic              i_resume_event,
  input  wire logic              i_done_a,
  input  wire logic              i_done_b,
  // bus line pins
  input  wire logic              i_dplus,
  input  wire logic              i_se0,
  // outputs
  output logic                   o_interrupt_request_output,
  output logic                   o_sof_send,
  output logic [FRAME_W-1:0]     o_frame_number,
  output logic                   o_full_features,
  output logic                   o_master_select,
  output logic                   o_polarity_swap
);
  logic [1:0]            dp_sync;
  logic [1:0]            se0_sync;
  logic                  se0_prev;
  logic [7:0]            flags;
  logic [7:0]            interval_low;
  logic [5:0]            interval_high;
  logic [INTERVAL_W-1:0] count;
  logic                  frame_tick;

  // only the second stage of each synchroniser is read
  wire dp_q  = dp_sync[1];
  wire se0_q = se0_sync[1];

  wire wr_flags = i_wr && (i_addr == ADDR_FLAGS);
  wire wr_low   = i_wr && (i_addr == ADDR_REV_LOW);
  wire wr_high  = i_wr && (i_addr == ADDR_HIGH_CNT);
  wire rd_flags = i_rd && (i_addr == ADDR_FLAGS);
  wire rd_rev   = i_rd && (i_addr == ADDR_REV_LOW);
  wire rd_high  = i_rd && (i_addr == ADDR_HIGH_CNT);

  wire line_change = i_host_mode && (se0_q != se0_prev);

  // hardware events for each sticky flag
  wire [7:0] set_vec = {1'b0,
                        i_resume_mode && i_resume_event,
                        line_change,
                        frame_tick,
                        2'b00,
                        i_done_b, i_done_a};

  // set beats clear so no event is lost during a clear
  wire [7:0] clr_vec    = wr_flags ? (i_wdata & FLAG_MASK) : 8'h00;
  wire [7:0] next_flags = ((flags & ~clr_vec) | set_vec) & FLAG_MASK;

  // bit 6 shows presence when resume mode is off
  wire       detect_bit = i_resume_mode ? flags[BIT_DETECT] : se0_q;
  wire [7:0] status_view = {dp_q, detect_bit, flags[BIT_INSERT],
                            flags[BIT_SOF], 2'b00,
                            flags[BIT_DONE_B], flags[BIT_DONE_A]};
  wire       pending    = |(status_view[6:0] & i_irq_enable[6:0]);

  wire [7:0] next_rdata =
    rd_flags ? status_view :
    rd_rev   ? {REVISION, 4'h0} :
    rd_high  ? count[INTERVAL_W-1:HIGH_SHIFT] :
    8'h00;

  // write clear takes priority over a same-cycle increment
  wire [FRAME_W-1:0] next_frame =
    wr_high    ? FRAME_RESET :
    frame_tick ? o_frame_number + FRAME_W'(1) :
    o_frame_number;

  sti_interval u_interval (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_enable (i_sof_enable),
    .i_low    (interval_low),
    .i_high   (interval_high),
    .o_count  (count),
    .o_tick   (frame_tick)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dp_sync  <= 2'b00;
      se0_sync <= 2'b11;
      se0_prev <= 1'b1;
    end else begin
      dp_sync  <= {dp_sync[0], i_dplus};
      se0_sync <= {se0_sync[0], i_se0};
      se0_prev <= se0_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags                      <= FLAGS_RESET;
      o_rdata                    <= 8'h00;
      o_interrupt_request_output <= 1'b0;
    end else begin
      flags                      <= next_flags;
      o_rdata                    <= next_rdata;
      o_interrupt_request_output <= pending;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      interval_low  <= LOW_RESET;
      interval_high <= HIGH_RESET;
      o_full_features <= 1'b0;
      o_master_select <= 1'b0;
      o_polarity_swap <= 1'b0;
    end else begin
      if (wr_low) begin
        interval_low <= i_wdata;
      end
      if (wr_high) begin
        interval_high   <= i_wdata[5:0];
        o_full_features <= 1'b1;
        o_master_select <= i_wdata[7];
        o_polarity_swap <= i_wdata[6];
      end
    end
  end

  // frame number goes out with the pulse that requests the packet
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_frame_number <= FRAME_RESET;
      o_sof_send     <= 1'b0;
    end else begin
      o_frame_number <= next_frame;
      o_sof_send     <= frame_tick;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_dplus_mirror: assert property (
    rd_flags |=> o_rdata[BIT_DPLUS] == $past(dp_q))
    else $error("status bit 7 does not show D+");
  a_presence_view: assert property (
    rd_flags && !i_resume_mode |=> o_rdata[BIT_DETECT] == $past(se0_q))
    else $error("presence bit wrong outside resume mode");
  a_resume_flag: assert property (
    i_resume_mode && i_resume_event |=> flags[BIT_DETECT])
    else $error("resume event not flagged");
  a_attach_flag: assert property (
    i_host_mode && se0_q != se0_prev |=> flags[BIT_INSERT])
    else $error("attach or detach not flagged");
  a_sof_flag: assert property (
    frame_tick |=> flags[BIT_SOF] && o_sof_send)
    else $error("frame tick not flagged");
  a_done_flags: assert property (
    (i_done_a |=> flags[BIT_DONE_A]) and (i_done_b |=> flags[BIT_DONE_B]))
    else $error("packet done not flagged");
  a_rev_read: assert property (
    rd_rev |=> o_rdata == {REVISION, 4'h0})
    else $error("revision read wrong");
  a_high_read: assert property (
    rd_high |=> o_rdata == $past(count[INTERVAL_W-1:HIGH_SHIFT]))
    else $error("high count read wrong");
  a_frame_clear: assert property (
    wr_high |=> o_frame_number == FRAME_RESET)
    else $error("frame number not cleared");
  a_frame_step: assert property (
    frame_tick && !wr_high |=> o_frame_number == $past(o_frame_number) + FRAME_W'(1))
    else $error("frame number did not step");
  a_clear_ones: assert property (
    wr_flags && set_vec == 8'h00 |=> flags == ($past(flags) & ~$past(i_wdata) & FLAG_MASK))
    else $error("status clear wrong");
  a_irq_level: assert property (
    pending [*2] |=> o_interrupt_request_output)
    else $error("interrupt request dropped while pending");
  a_sof_gated: assert property (
    !i_sof_enable && !wr_high |=> $stable(o_frame_number) && !o_sof_send)
    else $error("frame tick while generation off");
  a_reserved_zero: assert property (
    rd_flags |=> o_rdata[3:2] == 2'b00)
    else $error("reserved status bits not zero");
endmodule

// ==== sim/sti_bus_model.sv ====
// far-side bus model: line levels and received start-of-frame packets
module sti_bus_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // scenario control
  input  wire logic        i_attach,
  input  wire logic        i_full_speed,
  // frames from the host block
  input  wire logic        i_sof_send,
  input  wire logic [10:0] i_frame_number,
  // observation
  output logic             o_dplus,
  output logic             o_se0,
  output logic [7:0]       o_sof_count,
  output logic [10:0]      o_last_frame
);
  timeunit 1ns;
  timeprecision 100ps;
  // detached lines are pulled low; attached idle drives d+ only at full speed
  assign o_se0   = ~i_attach;
  assign o_dplus = i_attach & i_full_speed;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sof_count  <= 8'h00;
      o_last_frame <= 11'h000;
    end else if (i_sof_send) begin
      o_sof_count  <= o_sof_count + 8'h01;
      o_last_frame <= i_frame_number;
    end
  end
endmodule

// ==== sim/test_sti_timer.sv ====
// self-checking bench for the frame timer and interrupt status block
module test_sti_timer;
  import sti_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] a; logic [7:0] e;} sti_row_t;
  localparam sti_row_t ROWS [5] = '{'{8'h0D, 8'h40}, '{8'h0E, 8'h50}, '{8'h0F, 8'h00},
                                    '{8'h0C, 8'h00}, '{8'h10, 8'h00}};
  logic        i_clk = 0, i_rst = 1, wr = 0, rd = 0, host = 1, resume = 0, sof_en = 0;
  logic        res_ev = 0, done_a = 0, done_b = 0, attach = 0, full = 1;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, irq_en = 8'h13, rdata, sof_cnt;
  logic        irq, sof, dplus, se0, full_feat, master, polarity;
  logic [10:0] frame, last_frame;
  int          errors = 0, num_checks = 0, n, bad;

  always #2.5 i_clk = ~i_clk;

  sti_timer #(.REVISION(4'h5)) sti_timer_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
    .o_rdata(rdata), .i_host_mode(host), .i_resume_mode(resume), .i_sof_enable(sof_en),
    .i_irq_enable(irq_en), .i_resume_event(res_ev), .i_done_a(done_a), .i_done_b(done_b),
    .i_dplus(dplus), .i_se0(se0), .o_interrupt_request_output(irq), .o_sof_send(sof),
    .o_frame_number(frame), .o_full_features(full_feat), .o_master_select(master),
    .o_polarity_swap(polarity));

  sti_bus_model sti_bus_model_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_attach(attach), .i_full_speed(full),
    .i_sof_send(sof), .i_frame_number(frame), .o_dplus(dplus), .o_se0(se0),
    .o_sof_count(sof_cnt), .o_last_frame(last_frame));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    addr = a;
    wdata = v;
    wr = 1;
    @(negedge i_clk);
    wr = 0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    addr = a;
    rd = 1;
    @(negedge i_clk);
    rd = 0;
    chk(rdata, exp);
  endtask

  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1;
    @(negedge i_clk);
    s = 0;
  endtask

  // returns at the negedge that sees the pulse; n is the gap in cycles
  task automatic wait_sof();
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (sof !== 1'b1 && n < 20000);
    if (n >= 20000) errors++;
  endtask

  task automatic end_of_test();
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (3) @(negedge i_clk);
    i_rst = 0;
    foreach (ROWS[i]) rd_reg(ROWS[i].a, ROWS[i].e);
    chk(full_feat, 0);
    wr_reg(8'h0E, 8'h03);
    rd_reg(8'h0E, 8'h50);
    // packet done flags, then clear one at a time; reserved bits ignore ones
    pulse(done_a);
    pulse(done_b);
    rd_reg(8'h0D, 8'h43);
    chk(irq, 1);
    wr_reg(8'h0D, 8'h8D);
    rd_reg(8'h0D, 8'h42);
    chk(irq, 1);
    wr_reg(8'h0D, 8'h02);
    rd_reg(8'h0D, 8'h40);
    chk(irq, 0);
    // attach full speed, then detach
    attach = 1;
    repeat (5) @(negedge i_clk);
    rd_reg(8'h0D, 8'hA0);
    wr_reg(8'h0D, 8'h20);
    rd_reg(8'h0D, 8'h80);
    attach = 0;
    repeat (5) @(negedge i_clk);
    rd_reg(8'h0D, 8'h60);
    wr_reg(8'h0D, 8'h20);
    resume = 1;
    rd_reg(8'h0D, 8'h00);
    pulse(res_ev);
    rd_reg(8'h0D, 8'h40);
    wr_reg(8'h0D, 8'h40);
    rd_reg(8'h0D, 8'h00);
    resume = 0;
    // short interval of 3: four bit times per frame, about 66.7 cycles
    wr_reg(8'h0F, 8'h80);
    chk({full_feat, master, polarity}, 3'b110);
    sof_en = 1;
    wait_sof();
    chk(frame, 1);
    for (int k = 2; k <= 3; k++) begin
      wait_sof();
      chk(frame, k[10:0]);
      chk(n == 66 || n == 67, 1);
    end
    sof_en = 0;
    bad = 0;
    repeat (300) begin
      @(negedge i_clk);
      if (sof === 1'b1) bad++;
    end
    chk(bad, 0);
    chk(sof_cnt, 3);
    rd_reg(8'h0D, 8'h50);
    chk(irq, 1);
    // widest interval takes effect at the next reload; frame count restarts
    sof_en = 1;
    wr_reg(8'h0E, 8'hFF);
    wr_reg(8'h0F, 8'h3F);
    wait_sof();
    chk(frame, 1);
    rd_reg(8'h0F, 8'hFF);
    chk(last_frame, 1);
    // one millisecond setup, then a polarity swap; each write to 0Fh clears the frame
    wr_reg(8'h0E, 8'hE0);
    wr_reg(8'h0F, 8'hAE);
    chk(frame, 0);
    chk({full_feat, master, polarity}, 3'b110);
    wr_reg(8'h0F, 8'h6E);
    chk({full_feat, master, polarity}, 3'b101);
    // reset in mid-run with generation off, so the flags come back clean
    sof_en = 0;
    i_rst = 1;
    repeat (3) @(negedge i_clk);
    i_rst = 0;
    chk({sof, irq, full_feat, master, polarity}, 5'h00);
    chk(frame, 0);
    chk(sof_cnt, 0);
    chk(rdata, 0);
    foreach (ROWS[i]) rd_reg(ROWS[i].a, ROWS[i].e);
    // low-speed attach, then a detach that must not flag outside host mode
    full = 0;
    attach = 1;
    repeat (5) @(negedge i_clk);
    rd_reg(8'h0D, 8'h20);
    wr_reg(8'h0D, 8'h20);
    host = 0;
    attach = 0;
    repeat (5) @(negedge i_clk);
    rd_reg(8'h0D, 8'h40);
    // presence level raises the request once its enable is set
    irq_en = 8'h40;
    repeat (2) @(negedge i_clk);
    chk(irq, 1);
    end_of_test();
  end
endmodule
